/* File: design/tag_pkg.sv */
// Package: frame layout and timing constants for the transponder readout
package tag_pkg;
  localparam int CODE_BITS     = 64;
  localparam int HEADER_BITS   = 9;
  localparam int DATA_BITS     = 40;
  localparam int PARITY_BITS   = 14;
  localparam int STOP_BITS     = 1;
  localparam int CELL_CYCLES   = 64;
  localparam int HALF_CYCLES   = CELL_CYCLES / 2;
  localparam int FIFO_DEPTH    = 16;
  localparam int FIFO_WIDTH    = 1;
  localparam int ADDR_W        = $clog2(CODE_BITS);
  localparam int ROW_W         = 3;
  localparam int COL_W         = 3;
  localparam int DIV_W         = $clog2(CELL_CYCLES);
  localparam logic [63:0] CODE_RESET = 64'hFF80_0000_0000_0000;
  localparam logic        LINE_IDLE  = 1'b0;
endpackage

/* File: design/bit_stream_if.sv */
// Interface: serial bit stream between memory readout, FIFO and encoder
`timescale 1ns/100ps
interface bit_stream_if #(parameter int W = 1);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: design/bit_fifo.sv */
// Module: flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input  wire logic clk,
  input  wire logic rst_n,
  bit_stream_if.snk in_s,
  bit_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two, at least 2");
    if (WIDTH < 1) $error("WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_s.ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data  = mem_q[rd_q];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_s.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* File: design/rfid_manchester_readout.sv */
// Module: read-only tag readout, serialiser and Manchester encoder
`timescale 1ns/100ps
module rfid_manchester_readout
  import tag_pkg::*;
#(
  parameter logic [CODE_BITS-1:0] CODE = CODE_RESET
) (
  input  wire logic CLK,
  input  wire logic RESETN,
  output logic      MOD_OUT,
  output logic      FRAME_START,
  output logic      TX_ACTIVE
);

  initial begin
    if (HEADER_BITS + DATA_BITS + PARITY_BITS + STOP_BITS != CODE_BITS) $error("Frame fields do not fill the code");
    if ((1 << (ROW_W + COL_W)) != CODE_BITS) $error("Decoder does not cover the code");
  end

  // ----------------------------------------------------------------
  // Bit address and decoders
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_FILL = 2'b01, ST_RUN = 2'b10} run_t;

  bit_stream_if #(.W(FIFO_WIDTH)) fill_s ();
  bit_stream_if #(.W(FIFO_WIDTH)) drain_s ();

  logic [ADDR_W-1:0] addr_q;
  logic [ROW_W-1:0]  row;
  logic [COL_W-1:0]  col;
  logic [7:0]        row_sel;
  logic [7:0]        col_sel;
  logic              stored_bit;

  assign row     = addr_q[ADDR_W-1 -: ROW_W];
  assign col     = addr_q[COL_W-1:0];
  assign row_sel = 8'h01 << row;
  assign col_sel = 8'h01 << col;
  always_comb begin
    stored_bit = 1'b0;
    for (int r = 0; r < 8; r++) begin
      for (int c = 0; c < 8; c++) begin
        if (row_sel[r] && col_sel[c]) stored_bit = CODE[CODE_BITS-1-(r*8+c)];
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      addr_q <= '0;
    end else if (fill_s.valid && fill_s.ready) begin
      addr_q <= addr_q + 1'b1;
    end
  end

  assign fill_s.valid = 1'b1;
  assign fill_s.data  = stored_bit;

  bit_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk   (CLK),
    .rst_n (RESETN),
    .in_s  (fill_s),
    .out_s (drain_s)
  );

  // ----------------------------------------------------------------
  // Divider and encoder
  // ----------------------------------------------------------------
  // field clock only
  logic [DIV_W-1:0] div_q;
  run_t             state_q;
  logic             cell_bit_q;
  logic [ADDR_W-1:0] sent_q;
  logic             cell_end;
  logic             take;

  assign cell_end = (div_q == DIV_W'(CELL_CYCLES - 1));
  assign take = drain_s.valid && ((state_q == ST_FILL) || cell_end);
  assign drain_s.ready = take;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_FILL;
    end else begin
      case (state_q)
        ST_FILL: if (take) state_q <= ST_RUN;
        ST_RUN:  state_q <= ST_RUN;
        default: state_q <= ST_FILL;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      div_q <= '0;
    end else if (take) begin
      div_q <= '0;
    end else if (state_q == ST_RUN) begin
      div_q <= div_q + 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cell_bit_q <= 1'b0;
      sent_q     <= '0;
    end else if (take) begin
      cell_bit_q <= drain_s.data[0];
      sent_q     <= (state_q == ST_FILL) ? '0 : sent_q + 1'b1;
    end
  end

  // Output straight from flops; underflow holds the line at the last cell's late-half level since the FIFO never empties once running
  // mid-cell edge
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      MOD_OUT     <= LINE_IDLE;
      FRAME_START <= 1'b0;
      TX_ACTIVE   <= 1'b0;
    end else begin
      FRAME_START <= take && ((state_q == ST_FILL) || (sent_q == ADDR_W'(CODE_BITS - 1)));
      if (take) begin
        TX_ACTIVE <= 1'b1;
        MOD_OUT   <= ~drain_s.data[0];
      end else if (state_q == ST_RUN && div_q == DIV_W'(HALF_CYCLES - 1)) begin
        MOD_OUT <= cell_bit_q;
      end
    end
  end

endmodule

/* File: bench/readout_chk.sv */
// Checker: port timing of the tag readout
`timescale 1ns/100ps
module readout_chk
  import tag_pkg::*;
#(parameter logic [CODE_BITS-1:0] CODE = CODE_RESET) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic MOD_OUT,
  input wire logic FRAME_START,
  input wire logic TX_ACTIVE
);
  logic [12:0] c_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Offset lands the first cell on zero
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) c_q <= 13'h1FFE;
    else c_q <= FRAME_START ? 13'h0001 : c_q + 13'h0001;
  end
  sequence s_lo; FRAME_START && MOD_OUT == !CODE[63]; endsequence
  sequence s_hi; MOD_OUT == CODE[63]; endsequence
  property p_first; $rose(TX_ACTIVE) |-> s_lo ##32 s_hi; endproperty
  a_first: assert property (p_first) else $error("first cell");
  property p_mid; TX_ACTIVE && c_q[5:0] == 6'h20 |-> MOD_OUT != $past(MOD_OUT); endproperty
  a_mid: assert property (p_mid) else $error("mid edge");
  property p_hold; TX_ACTIVE && c_q[4:0] != 5'h00 |-> $stable(MOD_OUT); endproperty
  a_hold: assert property (p_hold) else $error("stray edge");
  property p_pulse; FRAME_START |=> !FRAME_START; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse");
  property p_per; TX_ACTIVE && $past(TX_ACTIVE) |-> FRAME_START == (c_q == 13'h1000); endproperty
  a_per: assert property (p_per) else $error("period");
  property p_keep; TX_ACTIVE |=> TX_ACTIVE; endproperty
  a_keep: assert property (p_keep) else $error("stopped");
  property p_idle; !TX_ACTIVE |-> !MOD_OUT && !FRAME_START; endproperty
  a_idle: assert property (p_idle) else $error("not idle");
  property p_fstx; FRAME_START |-> TX_ACTIVE; endproperty
  a_fstx: assert property (p_fstx) else $error("pulse idle");
endmodule
bind rfid_manchester_readout readout_chk #(.CODE(CODE)) readout_chk_i
  (.CLK, .RESETN, .MOD_OUT, .FRAME_START, .TX_ACTIVE);

/* File: bench/reader_model.sv */
// Reader model: recovers frames from the line
`timescale 1ns/100ps
module reader_model (
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   line,
  input  wire logic   sof,
  output logic [63:0] word_q
);
  logic [5:0]  pos_q;
  logic [63:0] sh_q;
  // bit is the late half level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q  <= 6'h00;
      sh_q   <= 64'h0;
      word_q <= 64'h0;
    end else begin
      pos_q <= sof ? 6'h01 : pos_q + 6'h01;
      if (pos_q == 6'h30) sh_q <= {sh_q[62:0], line};
      if (sof) word_q <= sh_q;
    end
  end
endmodule

/* File: bench/tb.sv */
// Testbench: frame content, frame period, reset start
`timescale 1ns/100ps
module tb;
  localparam logic [63:0] TCODE = 64'hFF8A_5C3E_1B47_D290;
  logic        CLK = 1'b0;
  logic        RESETN = 1'b0;
  logic        MOD_OUT;
  logic        FRAME_START;
  logic        TX_ACTIVE;
  logic [63:0] word;
  int          n_errors = 0;
  int          n_tests = 0;
  rfid_manchester_readout #(.CODE(TCODE)) rfid_manchester_readout_i
    (.CLK, .RESETN, .MOD_OUT, .FRAME_START, .TX_ACTIVE);
  reader_model reader_model_i (.clk(CLK), .rst_n(RESETN), .line(MOD_OUT), .sof(FRAME_START), .word_q(word));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) n_errors++;
    if (seen !== exp) $display("unexpected %0t seen %h exp %h", $time, seen, exp);
  endtask
  task automatic close_out;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Bounded wait, returns edges taken
  task automatic wait_fs(output int n);
    for (n = 1; n < 5000; n++) begin
      @(posedge CLK);
      #1;
      if (FRAME_START === 1'b1) break;
    end
  endtask
  task automatic t_start;
    int n;
    @(posedge CLK);
    RESETN <= 1'b0;
    @(posedge CLK);
    #1;
    check({MOD_OUT, FRAME_START, TX_ACTIVE}, 3'h0);
    @(posedge CLK);
    RESETN <= 1'b1;
    wait_fs(n);
    check(n, 2);
    check(TX_ACTIVE, 1'b1);
    check(MOD_OUT, !TCODE[63]);
  endtask
  // Word is latched one edge after the pulse; that edge belongs to the next frame's count
  task automatic t_frames;
    int n;
    int skew;
    skew = 0;
    repeat (2) begin
      wait_fs(n);
      check(n + skew, 4096);
      @(posedge CLK);
      #1;
      check(word, TCODE);
      skew = 1;
    end
  endtask
  initial forever #20 CLK = ~CLK;
  initial begin
    #800000;
    n_errors++;
    close_out();
  end
  initial begin
    t_start();
    t_frames();
    t_start();
    close_out();
  end
endmodule
